// file: pcf_pkg.sv
// Purpose: Shared constants and types for the parallel cable FIFO core
// Assumes: 100 MHz system clock on both ends
// Notes:   Offsets are byte addresses on the Avalon-MM register port
`default_nettype none
package pcf_pkg;
   // ==========================================================
   // Timing
   localparam int SYS_CLK_NS = 10;
   localparam int TX_CLK_MIN_NS = 50; // 20 MHz ceiling on cable clock
   // Half period rounds up so the clock never runs faster
   localparam int TX_HALF_CYC = (TX_CLK_MIN_NS / 2 + SYS_CLK_NS - 1) / SYS_CLK_NS;
   // ==========================================================
   // Widths and depths
   localparam int CBL_DW = 32;
   localparam int CBL_CW = 7;
   localparam int NUM_SRC = 16;
   localparam int FIFO_DEPTH_DEF = 32768;
   localparam int FIFO_DEPTH_MIN = 8192;
   localparam int FIFO_DEPTH_MAX = 131072;
   // ==========================================================
   // Register offsets
   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_STAT = 6'h04;
   localparam logic [5:0] REG_TXALM = 6'h08;
   localparam logic [5:0] REG_RXALM = 6'h0C;
   localparam logic [5:0] REG_FIFO = 6'h10;
   localparam logic [5:0] REG_TXCNT = 6'h14;
   localparam logic [5:0] REG_RXCNT = 6'h18;
   localparam logic [5:0] REG_TXSZ = 6'h1C;
   localparam logic [5:0] REG_RXSZ = 6'h20;
   localparam logic [5:0] REG_IEN = 6'h24;
   localparam logic [5:0] REG_ITYPE = 6'h28;
   localparam logic [5:0] REG_ILAT = 6'h2C;
   localparam logic [5:0] REG_SWNUM = 6'h30;
   // ==========================================================
   // Control register fields
   localparam int CTL_BRD = 0; // board_clear_bit
   localparam int CTL_TXC = 1; // transmit_clear_bit
   localparam int CTL_RXC = 2; // receive_clear_bit
   localparam int CTL_TXM = 4;
   localparam int CTL_RXM = 5;
   localparam int CTL_SEL = 10; // 6 bits: line used as discrete
   localparam int CTL_DIR = 16; // 6 bits: discrete is output
   localparam int CTL_VAL = 24; // 6 bits: discrete output value
   // ==========================================================
   // Cable control line indices
   localparam int CL_FV = 0;  // frame valid
   localparam int CL_LV = 1;  // line valid
   localparam int CL_SV = 2;  // status (header) valid
   localparam int CL_RDY = 3; // receiver ready
   localparam int CL_TDR = 4; // transmit data ready, per word
   localparam int CL_TXE = 5;
   localparam int CL_RXE = 6;
   // ==========================================================
   // Interrupt source positions
   localparam int SRC_FS = 0;
   localparam int SRC_FE = 1;
   localparam int SRC_CBL = 2;
   localparam int SRC_TXF = 8;
   localparam int SRC_RXF = 12;
   // ==========================================================
   // Reset values
   localparam logic [15:0] ALMOST_RST = 16'h0010;
   localparam logic [15:0] SWNUM_RST = 16'h0000;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      TRIG_RISE = 2'h0,
      TRIG_FALL = 2'h1,
      TRIG_HIGH = 2'h2,
      TRIG_LOW = 2'h3
   } pcf_trig_t;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SEND = 2'b10
   } pcf_tx_st_t;
endpackage : pcf_pkg
`default_nettype wire

// file: pcf_cbl_if.sv
// Purpose: Cable between the device end and the far end
// Assumes: Undriven lines read low
// Notes:   Wire levels are resolved here from each side's enables
`default_nettype none
interface pcf_cbl_if;
   import pcf_pkg::*;
   logic dev_clk_o, dev_clk_oe, hst_clk_o, hst_clk_oe;
   logic [CBL_DW-1:0] dev_d_o, hst_d_o;
   logic dev_d_oe, hst_d_oe;
   logic [CBL_CW-1:0] dev_c_o, dev_c_oe, hst_c_o, hst_c_oe;
   logic clk;
   logic [CBL_DW-1:0] d;
   logic [CBL_CW-1:0] c;
   // ==========================================================
   // Wire resolution
   assign clk = (dev_clk_oe & dev_clk_o) | (hst_clk_oe & hst_clk_o);
   assign d = ({CBL_DW{dev_d_oe}} & dev_d_o) | ({CBL_DW{hst_d_oe}} & hst_d_o);
   assign c = (dev_c_oe & dev_c_o) | (hst_c_oe & hst_c_o);
   modport dev (output dev_clk_o, dev_clk_oe, dev_d_o, dev_d_oe, dev_c_o, dev_c_oe,
                input clk, d, c);
   modport hst (output hst_clk_o, hst_clk_oe, hst_d_o, hst_d_oe, hst_c_o, hst_c_oe,
                input clk, d, c);
endinterface : pcf_cbl_if
`default_nettype wire

// file: pcf_fifo.sv
// Purpose: Word FIFO with count and four status flags
// Assumes: Depth is a power of two
// Notes:   Thresholds are captured only while clr_i is high
`default_nettype none
module pcf_fifo
   import pcf_pkg::*;
#(
   parameter int W = CBL_DW,
   parameter int DEPTH = FIFO_DEPTH_DEF
)(
   input wire logic sys_clk_i,
   input wire logic clr_i,
   input wire logic [15:0] ae_thr_i,
   input wire logic [15:0] af_thr_i,
   input wire logic wr_valid_i,
   input wire logic [W-1:0] wr_data_i,
   output logic wr_ready_o,
   output logic rd_valid_o,
   output logic [W-1:0] rd_data_o,
   input wire logic rd_ready_i,
   output logic [$clog2(DEPTH):0] count_o,
   output logic [3:0] flags_o
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < FIFO_DEPTH_MIN || DEPTH > FIFO_DEPTH_MAX || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("pcf_fifo depth unsupported");
   end
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic [15:0] ae;
      logic [15:0] af;
   } pcf_fifo_st_t;
   pcf_fifo_st_t st, nxt_st;
   logic [W-1:0] mem [DEPTH];
   logic push, pop, empty, full;
   // ==========================================================
   // Flags: almost empty counts from empty, almost full from full-1
   assign empty = st.cnt == '0;
   assign full = st.cnt == (AW+1)'(DEPTH);
   assign flags_o[0] = empty;
   assign flags_o[1] = 32'(st.cnt) <= 32'(st.ae);
   assign flags_o[2] = 32'(st.cnt) + 32'(st.af) >= DEPTH - 1;
   assign flags_o[3] = full;
   assign wr_ready_o = ~full & ~clr_i;
   assign rd_valid_o = ~empty & ~clr_i;
   assign rd_data_o = mem[st.rp];
   assign count_o = st.cnt;
   assign push = wr_valid_i & wr_ready_o;
   assign pop = rd_ready_i & rd_valid_o;
   // Pointer and level update
   always_comb
   begin
      nxt_st = st;
      if (push)
      begin
         nxt_st.wp = st.wp + 1'b1;
      end
      if (pop)
      begin
         nxt_st.rp = st.rp + 1'b1;
      end
      if (push && !pop)
      begin
         nxt_st.cnt = st.cnt + 1'b1;
      end
      else if (pop && !push)
      begin
         nxt_st.cnt = st.cnt - 1'b1;
      end
      if (clr_i)
      begin
         nxt_st = '0;
         nxt_st.ae = ae_thr_i;
         nxt_st.af = af_thr_i;
      end
   end
   always_ff @(posedge sys_clk_i)
   begin
      st <= nxt_st;
   end
   // Storage, no reset needed since pointers gate it
   always_ff @(posedge sys_clk_i)
   begin
      if (push)
      begin
         mem[st.wp] <= wr_data_i;
      end
   end
endmodule : pcf_fifo
`default_nettype wire

// file: pcf_dev.sv
// Purpose: Device end: FIFOs, cable engine, interrupt unit, Avalon-MM slave
// Assumes: Far end keeps its side of the cable handshake
// Notes:   Every access takes two cycles; waitrequest drops in the second
`default_nettype none
// Functional notes
// - Transmit or receive, never both at once
// - 32 data, one clock, seven control lines
// - Six control lines usable as discretes or interrupts
// - Cable synchronous to transmitter clock, max 20MHz
// - Frame valid marks words being sent
// - Header qualifier marks first programmed words
// - Record only while row qualifier is asserted
// - Receiver drives ready; transmitter pauses without it
// - Two 32-bit FIFOs with four flags each
// - Rx FIFO cable-filled; Tx FIFO bus-filled
// - Thresholds loaded only at FIFO clear
// - Almost empty from empty, almost full from full-1
// - Depth option 8k-128k; size readable
// - Live word count readable per FIFO
// - Clear bits act on one and self-clear
// - Board clear resets everything to defaults
// - Transmit clear empties Tx FIFO, loads thresholds
// - Receive clear empties Rx FIFO, loads thresholds
// - Sixteen interrupt sources
// - Per-source enable; Rx almost empty bit 13
// - Rise, fall, high or low trigger; edge default
// - Latched until software writes one
// - All latched sources onto one request
module pcf_dev
   import pcf_pkg::*;
#(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
)(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic irq_o,
   pcf_cbl_if.dev cbl
);
   localparam int CW = $clog2(FIFO_DEPTH) + 1;
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic brd_clr, tx_clr, rx_clr;
      logic tx_mode, rx_mode;
      logic [5:0] sel, dir, val;
      logic [15:0] tx_ae, tx_af, rx_ae, rx_af, sw_num;
      logic [15:0] ien, ilat, iprev;
      logic [31:0] itype;
      logic ck1, ck2, ckp;
      logic [CBL_DW-1:0] d1, d2;
      logic [CBL_CW-1:0] c1, c2;
      pcf_tx_st_t txs;
      logic [1:0] div;
      logic clk_o, sv, tdr;
      logic [CBL_DW-1:0] dout;
      logic [15:0] sw_cnt;
   } pcf_dev_st_t;
   pcf_dev_st_t st, nxt_st;
   logic req, acc, wr_acc, tx_push, tx_pop, rx_push, rx_pop, rx_act, frame;
   logic lv_use, sv_use, rdy_use, tdr_use, peer_ok, launch, fall;
   logic tx_vld, rx_vld;
   logic [31:0] rd_mux;
   logic [15:0] src, hit;
   logic [CBL_DW-1:0] tx_data, rx_data;
   logic [CW-1:0] tx_cnt, rx_cnt;
   logic [3:0] tx_flg, rx_flg;
   logic [15:0] tx_ae_ld, tx_af_ld, rx_ae_ld, rx_af_ld;
   // ==========================================================
   // FIFOs; board clear forces default thresholds
   assign tx_ae_ld = (rst_i | st.brd_clr) ? ALMOST_RST : st.tx_ae;
   assign tx_af_ld = (rst_i | st.brd_clr) ? ALMOST_RST : st.tx_af;
   assign rx_ae_ld = (rst_i | st.brd_clr) ? ALMOST_RST : st.rx_ae;
   assign rx_af_ld = (rst_i | st.brd_clr) ? ALMOST_RST : st.rx_af;
   pcf_fifo #(.W(CBL_DW), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .sys_clk_i(sys_clk_i),
      .clr_i(rst_i | st.brd_clr | st.tx_clr),
      .ae_thr_i(tx_ae_ld),
      .af_thr_i(tx_af_ld),
      .wr_valid_i(tx_push),
      .wr_data_i(avs_writedata_i),
      .wr_ready_o(),
      .rd_valid_o(tx_vld),
      .rd_data_o(tx_data),
      .rd_ready_i(tx_pop),
      .count_o(tx_cnt),
      .flags_o(tx_flg)
   );
   pcf_fifo #(.W(CBL_DW), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .sys_clk_i(sys_clk_i),
      .clr_i(rst_i | st.brd_clr | st.rx_clr),
      .ae_thr_i(rx_ae_ld),
      .af_thr_i(rx_af_ld),
      .wr_valid_i(rx_push),
      .wr_data_i(st.d2),
      .wr_ready_o(),
      .rd_valid_o(rx_vld),
      .rd_data_o(rx_data),
      .rd_ready_i(rx_pop),
      .count_o(rx_cnt),
      .flags_o(rx_flg)
   );
   // ==========================================================
   // Qualifier use follows the discrete selects
   assign lv_use = ~st.sel[CL_LV-1];
   assign sv_use = ~st.sel[CL_SV-1];
   assign rdy_use = ~st.sel[CL_RDY-1];
   assign tdr_use = ~st.sel[CL_TDR-1];
   assign rx_act = st.rx_mode & ~st.tx_mode;
   assign peer_ok = ~rdy_use | st.c2[CL_RDY];
   assign launch = st.tx_mode & ~st.clk_o & (st.div == 2'(TX_HALF_CYC - 1));
   assign fall = st.ckp & ~st.ck2;
   assign frame = st.tx_mode ? (st.txs == TX_SEND) : (rx_act & st.c2[CL_FV]);
   // Receive capture at cable falling edge, mid-bit
   assign rx_push = rx_act & fall & st.c2[CL_FV] & (~tdr_use | st.c2[CL_TDR])
                    & (~lv_use | st.c2[CL_LV]);
   assign tx_pop = launch & tx_vld & peer_ok;
   // ==========================================================
   // Bus slave
   assign req = avs_read_i | avs_write_i;
   assign acc = req & st.ack;
   assign wr_acc = avs_write_i & st.ack;
   assign avs_waitrequest_o = req & ~st.ack;
   assign avs_readdata_o = st.rdata;
   assign tx_push = wr_acc & (avs_address_i == REG_FIFO);
   assign rx_pop = avs_read_i & st.ack & (avs_address_i == REG_FIFO) & rx_vld;
   assign irq_o = |st.ilat;
   // Interrupt sources
   assign src = {rx_flg, tx_flg, st.c2[6:1], ~frame, frame};
   // Read data selection
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address_i)
         REG_CTRL: rd_mux = {2'h0, st.val, 2'h0, st.dir, st.sel, 4'h0, st.rx_mode,
                             st.tx_mode, 4'h0};
         REG_STAT: rd_mux = {15'h0000, frame, 2'h0, st.c2[6:1], rx_flg, tx_flg};
         REG_TXALM: rd_mux = {st.tx_af, st.tx_ae};
         REG_RXALM: rd_mux = {st.rx_af, st.rx_ae};
         REG_FIFO: rd_mux = rx_data;
         REG_TXCNT: rd_mux = 32'(tx_cnt);
         REG_RXCNT: rd_mux = 32'(rx_cnt);
         REG_TXSZ: rd_mux = 32'(FIFO_DEPTH);
         REG_RXSZ: rd_mux = 32'(FIFO_DEPTH);
         REG_IEN: rd_mux = {16'h0000, st.ien};
         REG_ITYPE: rd_mux = st.itype;
         REG_ILAT: rd_mux = {16'h0000, st.ilat};
         REG_SWNUM: rd_mux = {16'h0000, st.sw_num};
         default: rd_mux = 32'h0000_0000;
      endcase
   end
   // Trigger match per source, against last cycle's value
   always_comb
   begin
      for (int i = 0; i < NUM_SRC; i++)
      begin
         unique case (pcf_trig_t'(st.itype[2*i +: 2]))
            TRIG_RISE: hit[i] = src[i] & ~st.iprev[i];
            TRIG_FALL: hit[i] = ~src[i] & st.iprev[i];
            TRIG_HIGH: hit[i] = src[i];
            TRIG_LOW: hit[i] = ~src[i];
         endcase
      end
   end
   // Next state of everything else
   always_comb
   begin
      nxt_st = st;
      nxt_st.brd_clr = 1'b0;
      nxt_st.tx_clr = 1'b0;
      nxt_st.rx_clr = 1'b0;
      nxt_st.ck1 = cbl.clk;
      nxt_st.ck2 = st.ck1;
      nxt_st.ckp = st.ck2;
      nxt_st.d1 = cbl.d;
      nxt_st.d2 = st.d1;
      nxt_st.c1 = cbl.c;
      nxt_st.c2 = st.c1;
      nxt_st.ack = req & ~st.ack;
      if (req && !st.ack)
      begin
         nxt_st.rdata = rd_mux;
      end
      // Latch: a new hit wins over a clear in the same cycle
      nxt_st.iprev = src;
      nxt_st.ilat = st.ilat | (hit & st.ien);
      if (wr_acc)
      begin
         unique case (avs_address_i)
            REG_CTRL:
            begin
               nxt_st.brd_clr = avs_writedata_i[CTL_BRD];
               nxt_st.tx_clr = avs_writedata_i[CTL_TXC];
               nxt_st.rx_clr = avs_writedata_i[CTL_RXC];
               nxt_st.tx_mode = avs_writedata_i[CTL_TXM];
               nxt_st.rx_mode = avs_writedata_i[CTL_RXM];
               nxt_st.sel = avs_writedata_i[CTL_SEL +: 6];
               nxt_st.dir = avs_writedata_i[CTL_DIR +: 6];
               nxt_st.val = avs_writedata_i[CTL_VAL +: 6];
            end
            REG_TXALM: {nxt_st.tx_af, nxt_st.tx_ae} = avs_writedata_i;
            REG_RXALM: {nxt_st.rx_af, nxt_st.rx_ae} = avs_writedata_i;
            REG_IEN: nxt_st.ien = avs_writedata_i[15:0];
            REG_ITYPE: nxt_st.itype = avs_writedata_i;
            REG_ILAT: nxt_st.ilat = (st.ilat & ~avs_writedata_i[15:0])
                                    | (hit & st.ien);
            REG_SWNUM: nxt_st.sw_num = avs_writedata_i[15:0];
            default: nxt_st.rdata = st.rdata;
         endcase
      end
      // Cable clock divider, only while transmitting
      if (!st.tx_mode)
      begin
         nxt_st.div = 2'h0;
         nxt_st.clk_o = 1'b0;
         nxt_st.txs = TX_IDLE;
         nxt_st.tdr = 1'b0;
         nxt_st.sv = 1'b0;
         nxt_st.sw_cnt = 16'h0000;
      end
      else if (st.div == 2'(TX_HALF_CYC - 1))
      begin
         nxt_st.div = 2'h0;
         nxt_st.clk_o = ~st.clk_o;
      end
      else
      begin
         nxt_st.div = st.div + 2'h1;
      end
      // Words change on the same edge that raises the cable clock
      if (launch)
      begin
         unique case (st.txs)
            TX_IDLE, TX_SEND:
            begin
               if (tx_pop)
               begin
                  nxt_st.txs = TX_SEND;
                  nxt_st.dout = tx_data;
                  nxt_st.tdr = 1'b1;
                  nxt_st.sv = sv_use & (st.sw_cnt < st.sw_num);
                  if (st.sw_cnt != 16'hFFFF)
                  begin
                     nxt_st.sw_cnt = st.sw_cnt + 16'h0001;
                  end
               end
               else if (tx_vld)
               begin
                  nxt_st.tdr = 1'b0;
               end
               else
               begin
                  nxt_st.txs = TX_IDLE;
                  nxt_st.tdr = 1'b0;
                  nxt_st.sv = 1'b0;
                  nxt_st.sw_cnt = 16'h0000;
               end
            end
            default: nxt_st.txs = TX_IDLE;
         endcase
      end
   end
   // Single state register; board clear behaves as a full reset
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i || st.brd_clr)
      begin
         st <= '0;
         st.tx_ae <= ALMOST_RST;
         st.tx_af <= ALMOST_RST;
         st.rx_ae <= ALMOST_RST;
         st.rx_af <= ALMOST_RST;
         st.sw_num <= SWNUM_RST;
         st.txs <= TX_IDLE;
      end
      else
      begin
         st <= nxt_st;
      end
   end
   // ==========================================================
   // Cable pins; discretes override the default functions
   always_comb
   begin
      cbl.dev_clk_o = st.clk_o;
      cbl.dev_clk_oe = st.tx_mode;
      cbl.dev_d_o = st.dout;
      cbl.dev_d_oe = st.tx_mode;
      cbl.dev_c_o = {rx_act, st.tx_mode, st.tdr, ~rx_flg[2], st.sv, frame, frame};
      cbl.dev_c_oe = {2'b11, st.tx_mode & tdr_use, rx_act & rdy_use,
                      st.tx_mode & sv_use, st.tx_mode & lv_use, st.tx_mode};
      for (int k = 1; k < CBL_CW; k++)
      begin
         if (st.sel[k-1])
         begin
            cbl.dev_c_o[k] = st.val[k-1];
            cbl.dev_c_oe[k] = st.dir[k-1];
         end
      end
   end
endmodule : pcf_dev
`default_nettype wire

// file: pcf_hst.sv
// Purpose: Far end of the cable: simple transmitter or receiver
// Assumes: Device end is in the opposite mode
// Notes:   Uses every default qualifier; no discretes
`default_nettype none
module pcf_hst
   import pcf_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic tx_mode_i,
   input wire logic [15:0] sw_num_i,
   input wire logic tx_valid_i,
   input wire logic [CBL_DW-1:0] tx_data_i,
   output logic tx_ready_o,
   input wire logic rx_ready_i,
   output logic rx_valid_o,
   output logic [CBL_DW-1:0] rx_data_o,
   output logic rx_status_o,
   pcf_cbl_if.hst cbl
);
   typedef struct packed {
      logic ck1, ck2, ckp;
      logic [CBL_DW-1:0] d1, d2;
      logic [CBL_CW-1:0] c1, c2;
      logic [1:0] div;
      logic clk_o, fv, tdr, sv, rdy;
      logic [CBL_DW-1:0] dout;
      logic [15:0] sw_cnt;
      logic rx_v, rx_s;
      logic [CBL_DW-1:0] rx_d;
   } pcf_hst_st_t;
   pcf_hst_st_t st, nxt_st;
   logic launch, fall;
   // ==========================================================
   // Word taken from the user when the cable clock is about to rise
   assign launch = tx_mode_i & ~st.clk_o & (st.div == 2'(TX_HALF_CYC - 1));
   assign fall = st.ckp & ~st.ck2;
   assign tx_ready_o = launch & st.c2[CL_RDY];
   assign rx_valid_o = st.rx_v;
   assign rx_data_o = st.rx_d;
   assign rx_status_o = st.rx_s;
   // Next state
   always_comb
   begin
      nxt_st = st;
      nxt_st.ck1 = cbl.clk;
      nxt_st.ck2 = st.ck1;
      nxt_st.ckp = st.ck2;
      nxt_st.d1 = cbl.d;
      nxt_st.d2 = st.d1;
      nxt_st.c1 = cbl.c;
      nxt_st.c2 = st.c1;
      nxt_st.rdy = rx_ready_i;
      nxt_st.rx_v = 1'b0;
      if (!tx_mode_i)
      begin
         nxt_st.div = 2'h0;
         nxt_st.clk_o = 1'b0;
         nxt_st.fv = 1'b0;
         nxt_st.tdr = 1'b0;
         nxt_st.sv = 1'b0;
         nxt_st.sw_cnt = 16'h0000;
         // Capture mid-bit, on the falling cable edge
         if (fall && st.c2[CL_FV] && st.c2[CL_TDR] && st.c2[CL_LV])
         begin
            nxt_st.rx_v = 1'b1;
            nxt_st.rx_d = st.d2;
            nxt_st.rx_s = st.c2[CL_SV];
         end
      end
      else if (st.div == 2'(TX_HALF_CYC - 1))
      begin
         nxt_st.div = 2'h0;
         nxt_st.clk_o = ~st.clk_o;
      end
      else
      begin
         nxt_st.div = st.div + 2'h1;
      end
      if (launch)
      begin
         if (tx_valid_i && st.c2[CL_RDY])
         begin
            nxt_st.fv = 1'b1;
            nxt_st.tdr = 1'b1;
            nxt_st.dout = tx_data_i;
            nxt_st.sv = st.sw_cnt < sw_num_i;
            if (st.sw_cnt != 16'hFFFF)
            begin
               nxt_st.sw_cnt = st.sw_cnt + 16'h0001;
            end
         end
         else if (tx_valid_i)
         begin
            nxt_st.tdr = 1'b0;
         end
         else
         begin
            nxt_st.fv = 1'b0;
            nxt_st.tdr = 1'b0;
            nxt_st.sv = 1'b0;
            nxt_st.sw_cnt = 16'h0000;
         end
      end
   end
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         st <= '0;
      end
      else
      begin
         st <= nxt_st;
      end
   end
   // ==========================================================
   // Pins: transmitter drives clock, data and qualifiers
   always_comb
   begin
      cbl.hst_clk_o = st.clk_o;
      cbl.hst_clk_oe = tx_mode_i;
      cbl.hst_d_o = st.dout;
      cbl.hst_d_oe = tx_mode_i;
      cbl.hst_c_o = {2'b00, st.tdr, st.rdy, st.sv, st.fv, st.fv};
      cbl.hst_c_oe = {2'b00, tx_mode_i, ~tx_mode_i, tx_mode_i, tx_mode_i, tx_mode_i};
   end
endmodule : pcf_hst
`default_nettype wire

// file: pcf_monitor.sv
// Purpose: Checks on the resolved cable wires
// Assumes: Lines sampled on sys_clk_i
// Notes: Both ends are design code
`default_nettype none
module pcf_monitor
   import pcf_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic clk,
   input wire logic [CBL_DW-1:0] d,
   input wire logic [CBL_CW-1:0] c,
   input wire logic dev_d_oe,
   input wire logic hst_d_oe
);
   // ==========
   // Wire rules
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   chk_one_talker: assert property (!(dev_d_oe && hst_d_oe))
      else $error("both ends drive data");
   chk_mode_lines: assert property (!(c[CL_TXE] && c[CL_RXE]))
      else $error("tx and rx enabled together");
   chk_dev_talks: assert property (dev_d_oe |-> c[CL_TXE])
      else $error("device drives data outside tx mode");
   // Half period of 30 ns keeps the cable clock below its ceiling
   // A mode change may cut the clock together with the data drivers
   chk_clk_high: assert property ($rose(clk) |-> (clk || !(dev_d_oe || hst_d_oe)) [*3])
      else $error("cable clock high too short");
   chk_clk_low: assert property ($fell(clk) |-> !clk [*3])
      else $error("cable clock low too short");
   chk_data_hold: assert property ($rose(clk) && c[CL_FV] |=> $stable(d) [*5])
      else $error("data moved within a cable period");
   chk_word_frame: assert property (c[CL_TDR] |-> c[CL_FV])
      else $error("word valid outside frame");
   chk_head_frame: assert property (c[CL_SV] |-> c[CL_FV])
      else $error("header valid outside frame");
   // Main scenarios
   cover property ($rose(c[CL_FV]));
   cover property (c[CL_SV]);
   cover property (hst_d_oe && c[CL_TDR]);
endmodule : pcf_monitor
`default_nettype wire

// file: parallel_cable_fifo_irq_core_tb_top.sv
// Purpose: Drives both cable ends
// Assumes: Small FIFO depth
// Notes: Far end checks words
`default_nettype none
module parallel_cable_fifo_irq_core_tb_top
   import pcf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, rd = 0, wr = 0, tm = 0, tv = 0, irq, wrq, rv, rs, trdy;
   logic [5:0] adr = 6'h00;
   logic [31:0] wd = 32'h0, td = 32'h0, rdt, rdd, q;
   int bad_count = 0, check_count = 0;
   always #5 clk = ~clk;
   pcf_cbl_if cbl();
   pcf_dev #(.FIFO_DEPTH(8192)) u_pcf_dev (.sys_clk_i(clk), .rst_i(rst), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdt),
      .avs_waitrequest_o(wrq), .irq_o(irq), .cbl(cbl));
   pcf_hst u_pcf_hst (.sys_clk_i(clk), .rst_i(rst), .tx_mode_i(tm), .sw_num_i(16'h0000),
      .tx_valid_i(tv), .tx_data_i(td), .tx_ready_o(trdy), .rx_ready_i(1'b1),
      .rx_valid_o(rv), .rx_data_o(rdd), .rx_status_o(rs), .cbl(cbl));
   pcf_monitor u_pcf_monitor (.sys_clk_i(clk), .rst_i(rst), .clk(cbl.clk), .d(cbl.d),
      .c(cbl.c), .dev_d_oe(cbl.dev_d_oe), .hst_d_oe(cbl.hst_d_oe));
   task automatic wrap_up();
      $display("mismatches %0d checks %0d", bad_count, check_count);
      if (bad_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", n, e, s);
         bad_count++;
      end
   endtask : chk
   // Bounded wait for a flag, sampled at the rising edge as the design sees it
   task automatic wt(ref logic s);
      int n;
      n = 0;
      do @(posedge clk); while (s !== 1'b1 && n++ < 2000);
      if (s !== 1'b1)
      begin
         bad_count++;
         wrap_up();
      end
   endtask : wt
   // One Avalon access held until waitrequest is low at a rising edge
   task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] v);
      int n;
      n = 0;
      adr <= a;
      wd <= v;
      wr <= w;
      rd <= !w;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wrq !== 1'b0 && n < 2000);
      if (wrq !== 1'b0)
      begin
         bad_count++;
         wrap_up();
      end
      q = rdt;
      wr <= 1'b0;
      rd <= 1'b0;
      // Idle edge so the next call never re-drives a strobe in this step
      @(posedge clk);
   endtask : acc
   task automatic rck(input string n, input logic [5:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(n, e, q);
   endtask : rck
   task automatic t_reset();
      rck("txalm", REG_TXALM, {ALMOST_RST, ALMOST_RST});
      rck("size", REG_RXSZ, 32'h00002000);
      rck("stat", REG_STAT, 32'h00000433);
      rck("unmapped", 6'h3C, 32'h0);
   endtask : t_reset
   task automatic t_thresh();
      acc(1'b1, REG_TXALM, 32'h1FFD0002);
      acc(1'b1, REG_FIFO, 32'h0BAD0000);
      rck("old_thr", REG_STAT, 32'h00000432);
      acc(1'b1, REG_CTRL, 32'h00000002);
      rck("ctrl", REG_CTRL, 32'h0);
      for (int i = 0; i < 3; i++)
         acc(1'b1, REG_FIFO, 32'hC0DE0000 + i);
      rck("txcnt", REG_TXCNT, 32'h3);
      rck("new_thr", REG_STAT, 32'h00000434);
   endtask : t_thresh
   task automatic t_tx();
      acc(1'b1, REG_SWNUM, 32'h1);
      acc(1'b1, REG_CTRL, 32'h10);
      for (int i = 0; i < 3; i++)
      begin
         wt(rv);
         chk("word", 32'hC0DE0000 + i, rdd);
         chk("head", i == 0, rs);
      end
      rck("drained", REG_TXCNT, 32'h0);
   endtask : t_tx
   task automatic t_rx();
      acc(1'b1, REG_CTRL, 32'h20);
      tm <= 1'b1;
      tv <= 1'b1;
      td <= 32'h5EED0000;
      wt(trdy);
      @(posedge clk);
      td <= 32'h5EED0001;
      wt(trdy);
      @(posedge clk);
      tv <= 1'b0;
      for (int i = 0; i < 30 && q !== 32'h2; i++)
         acc(1'b0, REG_RXCNT, 32'h0);
      chk("rxcnt", 32'h2, q);
      rck("rx0", REG_FIFO, 32'h5EED0000);
      rck("rx1", REG_FIFO, 32'h5EED0001);
   endtask : t_rx
   task automatic t_irq();
      acc(1'b1, REG_ILAT, 32'h0000FFFF);
      acc(1'b1, REG_IEN, 32'h00001000);
      chk("edge_def", 32'h0, irq);
      acc(1'b1, REG_ITYPE, 32'h08000000);
      acc(1'b1, REG_IEN, 32'h00002000);
      rck("latch", REG_ILAT, 32'h00002000);
      chk("irq", 32'h1, irq);
      acc(1'b1, REG_ITYPE, 32'h0);
      acc(1'b1, REG_ILAT, 32'h00002000);
      chk("irq_clr", 32'h0, irq);
      acc(1'b1, REG_CTRL, 32'h01010400);
      rck("discrete", REG_CTRL, 32'h01010400);
      rck("line_out", REG_STAT, 32'h00000133);
      acc(1'b1, REG_CTRL, 32'h1);
      rck("ien_def", REG_IEN, 32'h0);
      rck("alm_def", REG_TXALM, {ALMOST_RST, ALMOST_RST});
   endtask : t_irq
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_thresh();
      t_tx();
      t_rx();
      t_irq();
      wrap_up();
   end
endmodule : parallel_cable_fifo_irq_core_tb_top
`default_nettype wire
